// ===== src/qpra_pkg.sv
// shared constants and state types for the quad pot register access block
package qpra_pkg;
  localparam int          CLK_MHZ       = 100;
  localparam int          NV_WRITE_US   = 5000;
  localparam int          NV_WRITE_CYC  = NV_WRITE_US * CLK_MHZ;
  localparam int          N_CH          = 4;
  localparam int          N_IDX         = 4;
  localparam logic [2:0]  SEL_ADDR      = 3'h7;
  localparam logic [2:0]  CH_LAST       = 3'h3;
  localparam int          SEL_EN_BIT    = 0;
  localparam int          SEL_IDX_LSB   = 1;
  localparam int          SEL_IDX_MSB   = 2;
  localparam logic [2:0]  SEL_RESET     = 3'h0;
  localparam logic [7:0]  SAVED_RESET   = 8'h00;
  localparam int          SA_TYPE_MSB   = 7;
  localparam int          SA_TYPE_LSB   = 4;
  localparam int          SA_ADDR_MSB   = 3;
  localparam int          SA_ADDR_LSB   = 1;
  localparam int          RW_SELECT_BIT = 0;
  localparam logic [3:0]  LAST_CNT      = 4'h7;
  localparam logic [3:0]  ACK_CNT       = 4'h8;
  localparam int          EV_ADDR       = 0;
  localparam int          EV_WR         = 1;
  localparam int          EV_RD         = 2;

  typedef enum logic [2:0] {LK_SLAVE, LK_ADDR, LK_DATA, LK_READ, LK_IGNORE} qpra_lk_state_t;

  typedef struct packed {
    logic [N_CH-1:0][7:0]             wiper;
    logic [N_CH-1:0][N_IDX-1:0][7:0]  saved;
    logic [2:0]                       sel;
    logic [2:0]                       ptr;
    logic [7:0]                       rd_data;
    logic                             nv_pend;
    logic                             scl_q;
    logic                             sda_q;
    logic                             start_d;
    logic                             link_run;
    logic [2:0]                       tgl_q;
  } qpra_ref_t;

  typedef struct packed {
    qpra_lk_state_t  state;
    logic [3:0]      cnt;
    logic [7:0]      sh;
    logic [7:0]      tx;
    logic            ack;
  } qpra_lk_t;

  typedef struct packed {
    logic [7:0]  addr_b;
    logic [7:0]  data_b;
    logic [2:0]  tgl;
  } qpra_ev_t;
endpackage : qpra_pkg

// ===== src/qpra_sync.sv
// two flip-flop level synchroniser, one stage pair per bit
`timescale 1ns/10ps
`default_nettype none
module qpra_sync #(
  parameter int W = 1
) (
  input  wire logic          clk_i,
  input  wire logic          reset_n_i,
  input  wire logic          ce_i,
  input  wire logic [W-1:0]  d_i,
  output logic      [W-1:0]  q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } qpra_sync_t;

  qpra_sync_t r;
  qpra_sync_t r_nxt;

  if (W < 1) begin : g_bad_w
    $error("qpra_sync: W must be at least 1");
  end

  always_comb begin
    r_nxt    = r;
    r_nxt.s1 = d_i;
    r_nxt.s2 = r.s1;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r <= '0;
    end else if (ce_i) begin
      r <= r_nxt;
    end
  end

  assign q_o = r.s2;
endmodule : qpra_sync
`default_nettype wire

// ===== src/qpra_nv_timer.sv
// nonvolatile write cycle timer, busy while counting down
`timescale 1ns/10ps
`default_nettype none
module qpra_nv_timer #(
  parameter int unsigned CYCLES = qpra_pkg::NV_WRITE_CYC
) (
  input  wire logic  clk_i,
  input  wire logic  reset_n_i,
  input  wire logic  ce_i,
  input  wire logic  start_i,
  output logic       busy_o
);
  localparam int W = $clog2(CYCLES + 1);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         busy;
  } qpra_tmr_t;

  qpra_tmr_t r;
  qpra_tmr_t r_nxt;

  if (CYCLES < 1) begin : g_bad_cycles
    $error("qpra_nv_timer: CYCLES must be at least 1");
  end

  always_comb begin
    r_nxt = r;
    if (start_i) begin
      r_nxt.cnt = W'(CYCLES);
    end else if (r.cnt != '0) begin
      r_nxt.cnt = r.cnt - W'(1);
    end
    r_nxt.busy = (r_nxt.cnt != '0);
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r <= '0;
    end else if (ce_i) begin
      r <= r_nxt;
    end
  end

  assign busy_o = r.busy;
endmodule : qpra_nv_timer
`default_nettype wire

// ===== src/qpra_core.sv
// two-wire slave with wiper and saved position registers for four pots
`timescale 1ns/10ps
`default_nettype none
module qpra_core #(
  parameter logic [3:0]  DEV_TYPE        = 4'ha,
  parameter int unsigned NV_WRITE_CYCLES = qpra_pkg::NV_WRITE_CYC
) (
  input  wire logic        ref_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        ce_i,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  input  wire logic        addr_strap_2_i,
  input  wire logic        addr_strap_1_i,
  input  wire logic        addr_strap_0_i,
  input  wire logic        write_protect_n_i,
  output logic      [7:0]  wiper_pos0_o,
  output logic      [7:0]  wiper_pos1_o,
  output logic      [7:0]  wiper_pos2_o,
  output logic      [7:0]  wiper_pos3_o,
  output logic             nv_busy_o
);
  // DEV_TYPE default is arbitrary

  qpra_pkg::qpra_ref_t  ref_r;
  qpra_pkg::qpra_ref_t  ref_nxt;
  qpra_pkg::qpra_lk_t   lk_r;
  qpra_pkg::qpra_lk_t   lk_nxt;
  qpra_pkg::qpra_ev_t   ev_r;
  qpra_pkg::qpra_ev_t   ev_nxt;
  logic                 sda_oe_r;
  logic                 sda_oe_nxt;

  logic [5:0]           ref_sync;
  logic [3:0]           lk_sync;
  logic                 scl_s;
  logic                 sda_s;
  logic                 wp_ok;
  logic [2:0]           tgl_s;
  logic [2:0]           straps_l;
  logic                 busy_l;
  logic                 nv_busy;
  logic                 nv_start;
  logic                 start_det;
  logic                 stop_det;
  logic                 addr_evt;
  logic                 wr_evt;
  logic                 rd_evt;
  logic [7:0]           wdata;
  logic [2:0]           wsel;
  logic [1:0]           wr_idx;
  logic                 sel_en;
  logic [1:0]           sel_idx;
  logic [1:0]           ptr_lo;
  logic                 ptr_is_ch;
  logic [7:0]           rd_pick;
  logic [7:0]           byte_in;
  logic                 link_rst_n;
  logic [3:0][7:0]      row_sel;
  logic [3:0][7:0]      row_wr;

  if (qpra_pkg::N_CH != 4 || qpra_pkg::N_IDX != 4) begin : g_bad_geom
    $error("qpra_core: channel and index counts must both be four");
  end

  // bus levels, write-protect and link event toggles into the reference domain
  qpra_sync #(.W (6)) u_ref_sync (
    .clk_i     (ref_clk_i),
    .reset_n_i (reset_n_i),
    .ce_i      (ce_i),
    .d_i       ({scl_i, sda_i, write_protect_n_i, ev_r.tgl}),
    .q_o       (ref_sync)
  );
  // straps and busy into the link domain; settles within the slave byte
  qpra_sync #(.W (4)) u_lk_sync (
    .clk_i     (scl_i),
    .reset_n_i (reset_n_i),
    .ce_i      (1'b1),
    .d_i       ({addr_strap_2_i, addr_strap_1_i, addr_strap_0_i, nv_busy}),
    .q_o       (lk_sync)
  );
  qpra_nv_timer #(.CYCLES (NV_WRITE_CYCLES)) u_nv_timer (
    .clk_i     (ref_clk_i),
    .reset_n_i (reset_n_i),
    .ce_i      (ce_i),
    .start_i   (nv_start),
    .busy_o    (nv_busy)
  );
  assign {scl_s, sda_s, wp_ok, tgl_s} = ref_sync;
  assign {straps_l, busy_l}           = lk_sync;

  assign start_det = ref_r.scl_q & scl_s & ref_r.sda_q & ~sda_s;
  assign stop_det  = ref_r.scl_q & scl_s & ~ref_r.sda_q & sda_s;
  assign addr_evt  = tgl_s[qpra_pkg::EV_ADDR] ^ ref_r.tgl_q[qpra_pkg::EV_ADDR];
  assign wr_evt    = tgl_s[qpra_pkg::EV_WR] ^ ref_r.tgl_q[qpra_pkg::EV_WR];
  assign rd_evt    = tgl_s[qpra_pkg::EV_RD] ^ ref_r.tgl_q[qpra_pkg::EV_RD];
  // event bytes are held in the link domain for a whole byte time after their toggle
  assign wdata     = ev_r.data_b;
  assign wsel      = wdata[qpra_pkg::SEL_IDX_MSB:0];
  assign wr_idx    = wdata[qpra_pkg::SEL_IDX_MSB:qpra_pkg::SEL_IDX_LSB];
  assign sel_en    = ref_r.sel[qpra_pkg::SEL_EN_BIT];
  assign sel_idx   = ref_r.sel[qpra_pkg::SEL_IDX_MSB:qpra_pkg::SEL_IDX_LSB];
  assign ptr_lo    = ref_r.ptr[1:0];
  assign ptr_is_ch = (ref_r.ptr <= qpra_pkg::CH_LAST);
  assign rd_pick   = ref_r.saved[ptr_lo][sel_idx];
  assign nv_start  = stop_det & ref_r.nv_pend;
  assign link_rst_n = ref_r.link_run;

  // one row of saved registers per bank index, current and newly written
  for (genvar j = 0; j < qpra_pkg::N_CH; j++) begin : g_row
    assign row_sel[j] = ref_r.saved[j][sel_idx];
    assign row_wr[j]  = ref_r.saved[j][wr_idx];
  end

  always_comb begin
    ref_nxt          = ref_r;
    ref_nxt.scl_q    = scl_s;
    ref_nxt.sda_q    = sda_s;
    ref_nxt.tgl_q    = tgl_s;
    ref_nxt.start_d  = start_det;
    // link logic held in reset between frames; start pulses it to restart the byte count
    if (start_det || stop_det) begin
      ref_nxt.link_run = 1'b0;
    end else if (ref_r.start_d) begin
      ref_nxt.link_run = 1'b1;
    end
    if (stop_det) begin
      ref_nxt.nv_pend = 1'b0;
    end
    if (addr_evt) begin
      ref_nxt.ptr = ev_r.addr_b[2:0];
    end
    if (wr_evt) begin
      if (ref_r.ptr == qpra_pkg::SEL_ADDR) begin
        ref_nxt.sel = wsel;
        if (wsel[qpra_pkg::SEL_EN_BIT]) begin
          ref_nxt.wiper = row_wr;
        end
      end else if (ptr_is_ch) begin
        if (!sel_en) begin
          ref_nxt.wiper[ptr_lo] = wdata;
        end else begin
          ref_nxt.wiper         = row_sel;
          ref_nxt.wiper[ptr_lo] = wdata;
          if (wp_ok) begin
            ref_nxt.saved[ptr_lo][sel_idx] = wdata;
            ref_nxt.nv_pend                = 1'b1;
          end
        end
      end
    end
    if (rd_evt && sel_en && ptr_is_ch) begin
      ref_nxt.wiper[ptr_lo] = rd_pick;
    end
    // read byte follows the pointer and bank; unused addresses read as zero
    if (ref_nxt.ptr == qpra_pkg::SEL_ADDR) begin
      ref_nxt.rd_data = 8'(ref_nxt.sel);
    end else if (ref_nxt.ptr > qpra_pkg::CH_LAST) begin
      ref_nxt.rd_data = '0;
    end else if (ref_nxt.sel[qpra_pkg::SEL_EN_BIT]) begin
      ref_nxt.rd_data = ref_nxt.saved[ref_nxt.ptr[1:0]]
                        [ref_nxt.sel[qpra_pkg::SEL_IDX_MSB:qpra_pkg::SEL_IDX_LSB]];
    end else begin
      ref_nxt.rd_data = ref_nxt.wiper[ref_nxt.ptr[1:0]];
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ref_r          <= '0;
      ref_r.wiper    <= {qpra_pkg::N_CH{qpra_pkg::SAVED_RESET}};
      ref_r.saved    <= {(qpra_pkg::N_CH * qpra_pkg::N_IDX){qpra_pkg::SAVED_RESET}};
      ref_r.sel      <= qpra_pkg::SEL_RESET;
      ref_r.scl_q    <= 1'b1;
      ref_r.sda_q    <= 1'b1;
    end else if (ce_i) begin
      ref_r <= ref_nxt;
    end
  end

  // link side: bits sampled on rising SCL, SDA driven after falling SCL
  always_comb begin
    lk_nxt  = lk_r;
    ev_nxt  = ev_r;
    byte_in = {lk_r.sh[6:0], sda_i};
    if (lk_r.cnt == qpra_pkg::ACK_CNT) begin
      lk_nxt.cnt = '0;
      lk_nxt.ack = 1'b0;
      if (lk_r.state == qpra_pkg::LK_READ) begin
        if (sda_i) begin
          lk_nxt.state = qpra_pkg::LK_IGNORE;
        end else begin
          lk_nxt.tx = ref_r.rd_data;
        end
      end
    end else begin
      lk_nxt.sh  = byte_in;
      lk_nxt.cnt = lk_r.cnt + 4'h1;
      if (lk_r.state == qpra_pkg::LK_READ) begin
        lk_nxt.tx = {lk_r.tx[6:0], 1'b0};
      end
      if (lk_r.cnt == qpra_pkg::LAST_CNT) begin
        unique case (lk_r.state)
          qpra_pkg::LK_SLAVE: begin
            if (byte_in[qpra_pkg::SA_TYPE_MSB:qpra_pkg::SA_TYPE_LSB] == DEV_TYPE
                && byte_in[qpra_pkg::SA_ADDR_MSB:qpra_pkg::SA_ADDR_LSB] == straps_l
                && !busy_l) begin
              lk_nxt.ack = 1'b1;
              if (byte_in[qpra_pkg::RW_SELECT_BIT]) begin
                lk_nxt.state = qpra_pkg::LK_READ;
                lk_nxt.tx    = ref_r.rd_data;
                ev_nxt.tgl[qpra_pkg::EV_RD] = ~ev_r.tgl[qpra_pkg::EV_RD];
              end else begin
                lk_nxt.state = qpra_pkg::LK_ADDR;
              end
            end else begin
              lk_nxt.state = qpra_pkg::LK_IGNORE;
            end
          end
          qpra_pkg::LK_ADDR: begin
            lk_nxt.ack    = 1'b1;
            lk_nxt.state  = qpra_pkg::LK_DATA;
            ev_nxt.addr_b = byte_in;
            ev_nxt.tgl[qpra_pkg::EV_ADDR] = ~ev_r.tgl[qpra_pkg::EV_ADDR];
          end
          qpra_pkg::LK_DATA: begin
            // extra bytes rewrite the same register; page increment is not served
            lk_nxt.ack    = 1'b1;
            ev_nxt.data_b = byte_in;
            ev_nxt.tgl[qpra_pkg::EV_WR] = ~ev_r.tgl[qpra_pkg::EV_WR];
          end
          qpra_pkg::LK_READ,
          qpra_pkg::LK_IGNORE: begin
            lk_nxt.ack = 1'b0;
          end
        endcase
      end
    end
    // ack phase drives the ack; a read byte drives zeros, master ack slot released
    if (lk_r.cnt == qpra_pkg::ACK_CNT) begin
      sda_oe_nxt = lk_r.ack;
    end else begin
      sda_oe_nxt = (lk_r.state == qpra_pkg::LK_READ) && !lk_r.tx[7];
    end
  end

  always_ff @(posedge scl_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      lk_r       <= '0;
      lk_r.state <= qpra_pkg::LK_SLAVE;
    end else begin
      lk_r <= lk_nxt;
    end
  end

  // toggles survive frame restarts, or a restart would fake an event
  always_ff @(posedge scl_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ev_r <= '0;
    end else begin
      ev_r <= ev_nxt;
    end
  end

  always_ff @(negedge scl_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      sda_oe_r <= 1'b0;
    end else begin
      sda_oe_r <= sda_oe_nxt;
    end
  end
  assign sda_o        = 1'b0;
  assign sda_oe_o     = sda_oe_r;
  assign wiper_pos0_o = ref_r.wiper[0];
  assign wiper_pos1_o = ref_r.wiper[1];
  assign wiper_pos2_o = ref_r.wiper[2];
  assign wiper_pos3_o = ref_r.wiper[3];
  assign nv_busy_o    = nv_busy;
  property p_sel_write;
    @(posedge ref_clk_i) disable iff (!reset_n_i || !ce_i)
    (wr_evt && ref_r.ptr == qpra_pkg::SEL_ADDR) |=> (ref_r.sel == $past(wsel));
  endproperty
  a_sel_write: assert property (p_sel_write)
    else $error("select control not loaded from data byte");
  property p_row_recall;
    @(posedge ref_clk_i) disable iff (!reset_n_i || !ce_i)
    (wr_evt && ref_r.ptr == qpra_pkg::SEL_ADDR && wsel[qpra_pkg::SEL_EN_BIT])
      |=> (ref_r.wiper == $past(row_wr));
  endproperty
  a_row_recall: assert property (p_row_recall)
    else $error("odd select write did not recall the row");
  property p_wiper_single;
    @(posedge ref_clk_i) disable iff (!reset_n_i || !ce_i)
    (wr_evt && ptr_is_ch && !sel_en) |=> (ref_r.wiper[$past(ptr_lo)] == $past(wdata));
  endproperty
  a_wiper_single: assert property (p_wiper_single)
    else $error("wiper write did not land");
  property p_read_load;
    @(posedge ref_clk_i) disable iff (!reset_n_i || !ce_i)
    (rd_evt && sel_en && ptr_is_ch) |=> (ref_r.wiper[$past(ptr_lo)] == $past(rd_pick));
  endproperty
  a_read_load: assert property (p_read_load)
    else $error("saved read did not load the wiper");
  property p_wp_hold;
    @(posedge ref_clk_i) disable iff (!reset_n_i || !ce_i)
    (wr_evt && sel_en && ptr_is_ch && !wp_ok) |=> $stable(ref_r.saved) && !ref_r.nv_pend;
  endproperty
  a_wp_hold: assert property (p_wp_hold)
    else $error("saved register changed while protected");
  property p_nv_start;
    @(posedge ref_clk_i) disable iff (!reset_n_i || !ce_i)
    (stop_det && ref_r.nv_pend) |=> nv_busy ##1 nv_busy;
  endproperty
  a_nv_start: assert property (p_nv_start)
    else $error("nonvolatile cycle did not start at stop");
  property p_vol_ready;
    @(posedge ref_clk_i) disable iff (!reset_n_i || !ce_i)
    (stop_det && !ref_r.nv_pend && !nv_busy) |=> !nv_busy && !ref_r.link_run;
  endproperty
  a_vol_ready: assert property (p_vol_ready)
    else $error("volatile write left the device busy");
  property p_nack_busy;
    @(posedge scl_i) disable iff (!link_rst_n)
    (lk_r.state == qpra_pkg::LK_SLAVE && lk_r.cnt == qpra_pkg::LAST_CNT && busy_l)
      |=> (lk_r.state == qpra_pkg::LK_IGNORE && !lk_r.ack);
  endproperty
  a_nack_busy: assert property (p_nack_busy)
    else $error("slave address acked during nonvolatile cycle");
  property p_ack_addr;
    @(posedge scl_i) disable iff (!link_rst_n)
    (lk_r.state == qpra_pkg::LK_ADDR && lk_r.cnt == qpra_pkg::LAST_CNT)
      |=> (lk_r.ack && lk_r.state == qpra_pkg::LK_DATA && lk_r.cnt == qpra_pkg::ACK_CNT);
  endproperty
  a_ack_addr: assert property (p_ack_addr)
    else $error("address byte not acknowledged");
  property p_release;
    @(posedge scl_i) disable iff (!link_rst_n)
    (lk_r.state == qpra_pkg::LK_IGNORE) |-> !sda_oe_r;
  endproperty
  a_release: assert property (p_release)
    else $error("data line driven while ignoring the master");
endmodule : qpra_core
`default_nettype wire

// ===== sim/qpra_master.sv
// two-wire bus master model for the quad pot block, own 12 ns tick
`timescale 1ns/10ps
`default_nettype none
module qpra_master #(
  parameter int HT = 8
) (
  input  wire logic  sda_i,
  output logic       scl_o,
  output logic       sda_oe_o
);
  logic  lk_clk;
  // phases of HT ticks keep start/stop hold well above the detector's two-flop delay
  initial begin
    lk_clk   = 1'b0;
    scl_o    = 1'b1;
    sda_oe_o = 1'b0;
  end
  always #6 lk_clk = ~lk_clk;
  task automatic tk();
    repeat (HT) @(posedge lk_clk);
  endtask : tk
  // sda changes only while scl is low; scl stands still between frames
  task automatic bit_x(input logic b, output logic r);
    sda_oe_o = !b;
    tk();
    scl_o = 1'b1;
    tk();
    r = sda_i;
    scl_o = 1'b0;
  endtask : bit_x
  task automatic start();
    sda_oe_o = 1'b0;
    tk();
    scl_o = 1'b1;
    tk();
    sda_oe_o = 1'b1;
    tk();
    scl_o = 1'b0;
  endtask : start
  task automatic stop();
    sda_oe_o = 1'b1;
    tk();
    scl_o = 1'b1;
    tk();
    sda_oe_o = 1'b0;
    tk();
  endtask : stop
  // slave byte, address byte and data byte go msb first; ninth clock samples the ack
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
    end
    bit_x(1'b1, r);
    ack = !r;
  endtask : wbyte
  task automatic rbyte(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, d[i]);
    end
    bit_x(!mack, r);
  endtask : rbyte
endmodule : qpra_master
`default_nettype wire

// ===== sim/tb.sv
// self-checking bench for the quad pot register access block
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam logic [3:0] DEV = 4'hc; // arbitrary device type value
  logic             ref_clk;
  logic             reset_n;
  logic             wp_n;
  logic [2:0]       strap;
  logic             scl;
  logic             m_oe;
  logic             d_sda;
  logic             d_oe;
  logic             sda_w;
  logic             nv_busy;
  logic [3:0][7:0]  wip;
  logic [7:0]       d;
  int               err_total;
  int               n_checks;
  // pull-up: released line reads high
  assign sda_w = (d_oe ? d_sda : 1'b1) & !m_oe;
  qpra_core #(.DEV_TYPE(DEV), .NV_WRITE_CYCLES(400)) qpra_core_inst (
    .ref_clk_i(ref_clk), .reset_n_i(reset_n), .ce_i(1'b1), .scl_i(scl), .sda_i(sda_w),
    .sda_o(d_sda), .sda_oe_o(d_oe), .addr_strap_2_i(strap[2]), .addr_strap_1_i(strap[1]),
    .addr_strap_0_i(strap[0]), .write_protect_n_i(wp_n), .wiper_pos0_o(wip[0]),
    .wiper_pos1_o(wip[1]), .wiper_pos2_o(wip[2]), .wiper_pos3_o(wip[3]), .nv_busy_o(nv_busy));
  qpra_master qpra_master_inst (.sda_i(sda_w), .scl_o(scl), .sda_oe_o(m_oe));
  always #5 ref_clk = ~ref_clk;
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk8
  task automatic chk1(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask : chk1
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up
  // upper address bits always sent as zero
  task automatic frame(input logic [2:0] a, input logic [7:0] v);
    logic k;
    qpra_master_inst.start();
    qpra_master_inst.wbyte({DEV, strap, 1'b0}, k);
    chk1("slave ack", 1'b1, k);
    qpra_master_inst.wbyte({5'h00, a}, k);
    chk1("addr ack", 1'b1, k);
    qpra_master_inst.wbyte(v, k);
    chk1("data ack", 1'b1, k);
  endtask : frame
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    frame(a, v);
    qpra_master_inst.stop();
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    logic k;
    qpra_master_inst.start();
    qpra_master_inst.wbyte({DEV, strap, 1'b0}, k);
    qpra_master_inst.wbyte({5'h00, a}, k);
    qpra_master_inst.start();
    qpra_master_inst.wbyte({DEV, strap, 1'b1}, k);
    chk1("read slave ack", 1'b1, k);
    qpra_master_inst.rbyte(1'b0, v);
    qpra_master_inst.stop();
  endtask : rd
  task automatic nv_wait();
    logic k;
    chk1("busy after stop", 1'b1, nv_busy);
    qpra_master_inst.start();
    qpra_master_inst.wbyte({DEV, strap, 1'b0}, k);
    chk1("poll ack", 1'b0, k);
    qpra_master_inst.stop();
    for (int i = 0; i < 1000 && nv_busy !== 1'b0; i++) @(posedge ref_clk);
    chk1("busy end", 1'b0, nv_busy);
  endtask : nv_wait
  initial begin
    ref_clk = 1'b0;
    reset_n = 1'b0;
    wp_n = 1'b1;
    strap = 3'h5;
    err_total = 0;
    n_checks = 0;
    repeat (2) @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (5) @(negedge ref_clk);
    for (int c = 0; c < 4; c++) chk8("wiper reset", 8'h00, wip[c]);
    chk1("busy reset", 1'b0, nv_busy);
    rd(3'h7, d);
    chk8("select reset", 8'h00, d);
    $display("test reset done");
    wr(3'h2, 8'h5a);
    chk8("wiper2", 8'h5a, wip[2]);
    chk8("wiper0 kept", 8'h00, wip[0]);
    rd(3'h2, d);
    chk8("wiper2 read", 8'h5a, d);
    $display("test wiper done");
    for (int i = 0; i < 4; i++) begin
      wr(3'h7, 8'(i * 2 + 1));
      wr(3'h3, 8'(8'h50 + i));
      nv_wait();
      chk8("saved write wiper3", 8'(8'h50 + i), wip[3]);
      chk8("row wiper2", 8'h00, wip[2]);
    end
    $display("test saved write done");
    for (int i = 3; i >= 0; i--) begin
      frame(3'h7, 8'(i * 2 + 1));
      chk8("recall at ack", 8'(8'h50 + i), wip[3]);
      qpra_master_inst.stop();
      rd(3'h3, d);
      chk8("bank read", 8'(8'h50 + i), d);
    end
    $display("test bank select done");
    wr(3'h7, 8'hfd);
    rd(3'h7, d);
    chk8("select reserved", 8'h05, d);
    chk8("recall index2", 8'h52, wip[3]);
    $display("test select bits done");
    @(negedge ref_clk);
    wp_n = 1'b0;
    wr(3'h7, 8'h03);
    wr(3'h0, 8'h99);
    chk8("protected wiper0", 8'h99, wip[0]);
    chk1("protected busy", 1'b0, nv_busy);
    rd(3'h0, d);
    chk8("protected saved", 8'h00, d);
    chk8("read load wiper0", 8'h00, wip[0]);
    @(negedge ref_clk);
    wp_n = 1'b1;
    $display("test protect done");
    wr(3'h7, 8'h00);
    wr(3'h0, 8'h11);
    chk8("wiper0 single", 8'h11, wip[0]);
    chk8("wiper3 kept", 8'h51, wip[3]);
    wr(3'h1, 8'h3c);
    chk8("wiper1 single", 8'h3c, wip[1]);
    chk8("wiper0 still", 8'h11, wip[0]);
    wr(3'h5, 8'h77);
    rd(3'h5, d);
    chk8("unused addr", 8'h00, d);
    $display("test address done");
    @(negedge ref_clk);
    strap = 3'h2;
    begin : bad_strap
      logic k;
      qpra_master_inst.start();
      qpra_master_inst.wbyte({DEV, 3'h5, 1'b0}, k);
      chk1("strap mismatch ack", 1'b0, k);
      qpra_master_inst.stop();
      qpra_master_inst.start();
      qpra_master_inst.wbyte({~DEV, 3'h2, 1'b0}, k);
      chk1("type mismatch ack", 1'b0, k);
      qpra_master_inst.stop();
      qpra_master_inst.start();
      qpra_master_inst.wbyte({DEV, 3'h2, 1'b0}, k);
      chk1("new strap ack", 1'b1, k);
      qpra_master_inst.stop();
    end
    $display("test strap done");
    wrap_up();
  end
  // the whole sequence needs well under half of this span
  initial begin
    #900000;
    err_total++;
    $display("Error watchdog expected finish seen timeout");
    wrap_up();
  end
endmodule : tb
`default_nettype wire
